// [pkg/dwos_pkg.sv]
// dwos_pkg: constants and types shared by the dual watchdog output safety block
// assumes a 20 MHz system clock; times below are converted to cycles here
package dwos_pkg;
  localparam int CLK_HZ = 20_000_000;
  // module watchdog: firmware must kick within this time (ms)
  localparam int MOD_WDT_MS = 1000;
  localparam int MOD_WDT_CYCLES = (CLK_HZ / 1000) * MOD_WDT_MS;
  // length of the processor reset pulse (us), least time rounded up
  localparam int CPU_RST_US = 10;
  localparam int CPU_RST_CYCLES = (CLK_HZ / 1_000_000) * CPU_RST_US;
  // communication timeout unit: one tick is 100 ms
  localparam int COMM_TICK_MS = 100;
  localparam int COMM_TICK_CYCLES = (CLK_HZ / 1000) * COMM_TICK_MS;
  localparam int COMM_TO_W = 8;
  localparam logic [COMM_TO_W-1:0] COMM_TO_RST = 8'h0A;
  // output source, reported for status
  typedef enum logic [1:0] {
    DWOS_SRC_POWERON,
    DWOS_SRC_CMD,
    DWOS_SRC_SAFE
  } dwos_src_e;
endpackage

// [hw/dwos_timer.sv]
// dwos_timer: restartable down-counter, pulses done when it runs out
// assumes the caller holds restart for a cycle to reload; enable gates counting
module dwos_timer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic enable,
  input wire logic [W-1:0] load,
  output logic done
);
  logic [W-1:0] cnt_r;

  // reload on restart, count while enabled, fire once on reaching one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      done <= 1'b0;
    end else if (restart || !enable) begin
      cnt_r <= load;
      done <= 1'b0;
    end else if (cnt_r > W'(1)) begin
      cnt_r <= cnt_r - W'(1);
      done <= 1'b0;
    end else begin
      cnt_r <= load; // rearm so a silent link keeps reporting
      done <= 1'b1;
    end
  end
endmodule

// [hw/dwos_top.sv]
// dwos_top: module watchdog, communication watchdog and output source selection
// assumes host commands arrive as one-cycle strobes already decoded from the network
// assumes stored power-on and safe values are held steady by whoever owns them
//
// Summary of operation
// - module watchdog resets processor on failure
// - after watchdog reset, load power-on values
// - power-on values on power-up, watchdog, command reset
// - programmable comm timeout without host commands
// - comm timeout forces outputs to safe values
// - safe values only while comm watchdog enabled
// - set-output commands drive outputs otherwise
module dwos_top #(
  parameter int N_AO = 4,
  parameter int AO_W = 16,
  parameter int N_DO = 8,
  parameter int MOD_CYC = dwos_pkg::MOD_WDT_CYCLES,
  parameter int TICK_CYC = dwos_pkg::COMM_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_kick,
  input wire logic cpu_fault,
  input wire logic host_cmd,
  input wire logic set_out,
  input wire logic [N_AO*AO_W-1:0] set_ao,
  input wire logic [N_DO-1:0] set_do,
  input wire logic reset_cmd,
  input wire logic comm_wdt_en,
  input wire logic [dwos_pkg::COMM_TO_W-1:0] comm_timeout,
  input wire logic [N_AO*AO_W-1:0] poweron_ao,
  input wire logic [N_DO-1:0] poweron_do,
  input wire logic [N_AO*AO_W-1:0] safe_ao,
  input wire logic [N_DO-1:0] safe_do,
  output logic cpu_rst,
  output logic [N_AO*AO_W-1:0] analog_output_channel,
  output logic [N_DO-1:0] digital_output,
  output logic comm_timed_out,
  output logic [1:0] out_source
);
  import dwos_pkg::*;

  // internal timing state; the tick counter is as wide as the timeout field
  logic mod_bite;
  logic tick;
  logic poweron_pend_r;
  logic [15:0] rst_cnt_r;
  logic [COMM_TO_W-1:0] tick_cnt_r;
  logic comm_to_pulse;

  // module watchdog: no kick in time or explicit fault bites
  // pausing it in reset trades early detection for never biting a processor still held
  dwos_timer #(.W(32)) u_mod_wdt (
    .clk(clk),
    .rst(rst),
    .restart(cpu_kick),
    .enable(!cpu_rst),
    .load(32'(MOD_CYC)),
    .done(mod_bite)
  );

  // processor reset pulse, stretched to a minimum width
  // a fresh cause restarts the width count, so back-to-back causes merge into one pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_rst <= 1'b1; // processor held in reset with the block
      rst_cnt_r <= 16'(CPU_RST_CYCLES);
    end else if (mod_bite || cpu_fault || reset_cmd) begin
      cpu_rst <= 1'b1;
      rst_cnt_r <= 16'(CPU_RST_CYCLES);
    end else if (rst_cnt_r != 16'h0000) begin
      rst_cnt_r <= rst_cnt_r - 16'h0001;
    end else begin
      cpu_rst <= 1'b0;
    end
  end

  // power-on load requested by power-up, watchdog bite or command reset
  // the pending flag delays the load a cycle so it lands after the processor reset rises
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      poweron_pend_r <= 1'b1;
    end else begin
      poweron_pend_r <= mod_bite || cpu_fault || reset_cmd;
    end
  end

  // tick prescaler for the communication timeout
  dwos_timer #(.W(32)) u_tick (
    .clk(clk),
    .rst(rst),
    .restart(1'b0),
    .enable(1'b1),
    .load(32'(TICK_CYC)),
    .done(tick)
  );

  // communication watchdog: counts ticks since the last host command
  // clearing beats setting: a command in the expiring cycle shows the link is alive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
      comm_timed_out <= 1'b0;
    end else if (host_cmd || !comm_wdt_en || cpu_rst) begin
      tick_cnt_r <= '0;
      comm_timed_out <= 1'b0;
    end else if (tick && !comm_timed_out) begin
      tick_cnt_r <= tick_cnt_r + COMM_TO_W'(1);
      if (tick_cnt_r + COMM_TO_W'(1) >= comm_timeout && comm_timeout != '0) begin
        comm_timed_out <= 1'b1;
      end
    end
  end
  // zero timeout never expires, though the tick count still runs; level only needs to rise once
  assign comm_to_pulse = tick && !comm_timed_out && comm_wdt_en && !host_cmd && !cpu_rst &&
                         comm_timeout != '0 && (tick_cnt_r + COMM_TO_W'(1) >= comm_timeout);

  // output source selection: reset loads beat commands, commands beat safe values
  // a timeout that coincides with a command is dropped, the command already restarted the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analog_output_channel <= '0;
      digital_output <= '0;
      out_source <= 2'(DWOS_SRC_POWERON);
    end else if (poweron_pend_r) begin
      analog_output_channel <= poweron_ao;
      digital_output <= poweron_do;
      out_source <= 2'(DWOS_SRC_POWERON);
    end else if (set_out && !cpu_rst) begin
      analog_output_channel <= set_ao;
      digital_output <= set_do;
      out_source <= 2'(DWOS_SRC_CMD);
    end else if (comm_to_pulse && comm_wdt_en) begin
      analog_output_channel <= safe_ao;
      digital_output <= safe_do;
      out_source <= 2'(DWOS_SRC_SAFE);
    end
    // otherwise outputs hold their last values
  end

  // reset causes are followed by a reset pulse next cycle
  sequence bite_s;
    mod_bite || cpu_fault;
  endsequence
  wdt_reset_out_a: assert property (@(posedge clk) disable iff (rst) bite_s |=> cpu_rst)
    else $error("processor reset missing after watchdog bite");
  poweron_load_a: assert property (@(posedge clk) disable iff (rst)
    (mod_bite || reset_cmd) |=> ##1 (digital_output == $past(poweron_do) && out_source == 2'(DWOS_SRC_POWERON)))
    else $error("power-on values not loaded after reset event");
  poweron_only_a: assert property (@(posedge clk) disable iff (rst)
    (out_source == 2'(DWOS_SRC_POWERON) && $changed(out_source)) |-> $past(poweron_pend_r))
    else $error("power-on source without a reset event");
  comm_timeout_a: assert property (@(posedge clk) disable iff (rst)
    comm_to_pulse |=> comm_timed_out)
    else $error("timeout not flagged");
  safe_load_a: assert property (@(posedge clk) disable iff (rst)
    (comm_to_pulse && !poweron_pend_r && !set_out) |=> (digital_output == $past(safe_do)))
    else $error("safe values not applied on timeout");
  safe_gate_a: assert property (@(posedge clk) disable iff (rst)
    !comm_wdt_en |=> !comm_timed_out)
    else $error("timeout while watchdog disabled");
  set_apply_a: assert property (@(posedge clk) disable iff (rst)
    (set_out && !cpu_rst && !poweron_pend_r) |=> (digital_output == $past(set_do)))
    else $error("commanded values not applied");
  cmd_restart_a: assert property (@(posedge clk) disable iff (rst)
    host_cmd |=> (tick_cnt_r == '0 && !comm_timed_out))
    else $error("host command did not restart count");

  // a stretched reset must not drop while its width count is still running
  rst_stretch_a: assert property (@(posedge clk) disable iff (rst)
    (cpu_rst && rst_cnt_r != 16'h0000) |=> cpu_rst)
    else $error("processor reset released before its minimum width");

  // the watchdog is paused during a processor reset, so it cannot bite again
  wdt_paused_a: assert property (@(posedge clk) disable iff (rst)
    cpu_rst |=> !mod_bite)
    else $error("watchdog bit while the processor was held in reset");

  // a command reset pulses the processor reset just like a bite
  cmd_reset_out_a: assert property (@(posedge clk) disable iff (rst)
    reset_cmd |=> cpu_rst)
    else $error("processor reset missing after reset command");

  // full power-on image, analog channels included, two cycles after any reset cause
  sequence reset_cause_s;
    mod_bite || cpu_fault || reset_cmd;
  endsequence
  sequence poweron_image_s;
    analog_output_channel == $past(poweron_ao) && digital_output == $past(poweron_do) &&
      out_source == 2'(DWOS_SRC_POWERON);
  endsequence
  poweron_image_a: assert property (@(posedge clk) disable iff (rst)
    reset_cause_s |=> ##1 poweron_image_s)
    else $error("power-on image not loaded after reset cause");

  // commanded analog values and source code follow a set-output command
  set_analog_a: assert property (@(posedge clk) disable iff (rst)
    (set_out && !cpu_rst && !poweron_pend_r) |=>
      (analog_output_channel == $past(set_ao) && out_source == 2'(DWOS_SRC_CMD)))
    else $error("commanded analog values not applied");

  // safe analog values and source code follow a timeout
  safe_analog_a: assert property (@(posedge clk) disable iff (rst)
    (comm_to_pulse && !poweron_pend_r && !set_out) |=>
      (analog_output_channel == $past(safe_ao) && out_source == 2'(DWOS_SRC_SAFE)))
    else $error("safe analog values not applied on timeout");

  // with the link watchdog off, no cycle may switch the outputs to safe values
  safe_disabled_a: assert property (@(posedge clk) disable iff (rst)
    (!comm_wdt_en && out_source != 2'(DWOS_SRC_SAFE)) |=> out_source != 2'(DWOS_SRC_SAFE))
    else $error("safe values loaded while watchdog disabled");

  // without a load event the outputs keep what they last took
  output_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!poweron_pend_r && !(set_out && !cpu_rst) && !comm_to_pulse) |=>
      ($stable(analog_output_channel) && $stable(digital_output) && $stable(out_source)))
    else $error("outputs changed without a load event");

  // the timeout flag rises only on an expiring tick, never by itself
  timeout_cause_a: assert property (@(posedge clk) disable iff (rst)
    (!comm_timed_out && !comm_to_pulse) |=> !comm_timed_out)
    else $error("timeout flagged without an expiring tick");
endmodule

// [test/dwos_host.sv]
// dwos_host: remote host model issuing decoded commands
// assumes the bench calls send; lines change only after rising edges
module dwos_host (
  input wire logic clk,
  output logic host_cmd,
  output logic set_out,
  output logic [15:0] set_ao,
  output logic [3:0] set_do,
  output logic reset_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {host_cmd, set_out, reset_cmd, set_ao, set_do} = '0;
  end
  // one-cycle command; data inverted afterwards so stale values never match
  task automatic send(input logic setp, input logic rstp, input logic [19:0] v);
    @(posedge clk);
    host_cmd <= 1'b1;
    set_out <= setp;
    reset_cmd <= rstp;
    {set_ao, set_do} <= v;
    @(posedge clk);
    {host_cmd, set_out, reset_cmd} <= 3'h0;
    {set_ao, set_do} <= ~v;
  endtask
endmodule

// [test/dwos_top_tb.sv]
// dwos_top_tb: self-checking bench for the output safety block
// assumes short watchdog counts: 100 cycle bite, 10 cycle tick
module dwos_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cpu_fault, kick_en, comm_wdt_en;
  logic cpu_kick = 1'b0;
  logic host_cmd, set_out, reset_cmd, cpu_rst, comm_timed_out;
  logic [15:0] set_ao, ao;
  logic [3:0] set_do, dout;
  logic [7:0] comm_timeout;
  logic [1:0] src;
  int fail_count, checks;
  localparam logic [19:0] PON = 20'hA5C39;
  localparam logic [19:0] SAFE = 20'h3C5A6;
  logic [19:0] rows [4] = '{20'h12345, 20'hFFFFF, 20'h00000, 20'h80001};
  wire logic [23:0] obs = {comm_timed_out, cpu_rst, src, ao, dout};
  dwos_top #(.N_AO(2), .AO_W(8), .N_DO(4), .MOD_CYC(100), .TICK_CYC(10)) i_dwos_top (
    .clk(clk), .rst(rst), .cpu_kick(cpu_kick), .cpu_fault(cpu_fault), .host_cmd(host_cmd),
    .set_out(set_out), .set_ao(set_ao), .set_do(set_do), .reset_cmd(reset_cmd),
    .comm_wdt_en(comm_wdt_en), .comm_timeout(comm_timeout), .poweron_ao(PON[19:4]),
    .poweron_do(PON[3:0]), .safe_ao(SAFE[19:4]), .safe_do(SAFE[3:0]), .cpu_rst(cpu_rst),
    .analog_output_channel(ao), .digital_output(dout), .comm_timed_out(comm_timed_out),
    .out_source(src));
  dwos_host i_dwos_host (.clk(clk), .host_cmd(host_cmd), .set_out(set_out),
    .set_ao(set_ao), .set_do(set_do), .reset_cmd(reset_cmd));
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // bounded wait on the timeout flag (to=1) or the processor reset
  task automatic wait_sig(input bit to, input logic want, input int lim);
    int n;
    n = 0;
    while (((to ? comm_timed_out : cpu_rst) !== want) && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      finish_test();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // firmware alive pulses every other cycle while allowed
  always @(posedge clk) cpu_kick <= kick_en & ~cpu_kick;
  initial begin
    {rst, cpu_fault, kick_en, comm_wdt_en} = 4'b1010;
    comm_timeout = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    check("in_reset", obs, 24'h400000);
    @(posedge clk);
    rst <= 1'b0;
    wait_sig(0, 0, 300);
    check("power_up", obs, {4'h0, PON});
    foreach (rows[i]) begin
      i_dwos_host.send(1'b1, 1'b0, rows[i]);
      #1;
      check("set_out", obs, {4'h1, rows[i]});
    end
    @(posedge clk);
    comm_wdt_en <= 1'b1;
    comm_timeout <= 8'h02;
    i_dwos_host.send(1'b0, 1'b0, 20'h0);
    repeat (8) @(posedge clk);
    #1;
    check("early", obs, {4'h1, rows[3]});
    wait_sig(1, 1, 40);
    check("safe", obs, {4'hA, SAFE});
    i_dwos_host.send(1'b1, 1'b0, rows[1]);
    #1;
    check("resume", obs, {4'h1, rows[1]});
    @(posedge clk);
    comm_wdt_en <= 1'b0;
    repeat (60) @(posedge clk);
    #1;
    check("disabled", obs, {4'h1, rows[1]});
    i_dwos_host.send(1'b0, 1'b1, 20'h0);
    #1;
    wait_sig(0, 1, 5);
    @(posedge clk);
    #1;
    check("cmd_reset", obs, {4'h4, PON});
    wait_sig(0, 0, 300);
    i_dwos_host.send(1'b1, 1'b0, rows[0]);
    kick_en <= 1'b0;
    wait_sig(0, 1, 300);
    @(posedge clk);
    #1;
    check("bite", obs, {4'h4, PON});
    kick_en <= 1'b1;
    wait_sig(0, 0, 300);
    i_dwos_host.send(1'b1, 1'b0, rows[3]);
    cpu_fault <= 1'b1;
    @(posedge clk);
    cpu_fault <= 1'b0;
    #1;
    wait_sig(0, 1, 5);
    check("fault", obs[22], 1'b1);
    @(posedge clk);
    #1;
    check("fault_load", obs, {4'h4, PON});
    // asynchronous reset in mid-run: outputs clear, then the power-on image returns
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    check("mid_reset", obs, 24'h400000);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("reset_load", obs, {4'h4, PON});
    finish_test();
  end
endmodule
